/* logic/asp_ctrl.sv */
/*
 asp_ctrl: controller that drives a 512K x 8 asynchronous static memory through its pins.
 assumes a 20 MHz clock; the memory itself is outside and keeps its own timing promises.
*/
// Contract
// - the write is ended by raising write strobe before select.
// - address changes only while write strobe is high.
// - address stands from the start of the write until past the pulse end.
// - write pulse and whole write cycle meet their least lengths.
// - address is held until after the terminating edge.
// - write data is driven from write start until after the strobe rises.
// - the controller drives data only while output drive is high.
module asp_ctrl
   import asp_pkg::*;
(
   // clock and reset
   input  wire logic                  core_clk_in,
   input  wire logic                  nrst_in,
   // user request
   input  wire asp_pkg::asp_req_s     req_in,
   output logic                       req_ready_out,
   output logic                       rd_valid_out,
   output logic [asp_pkg::ASP_DATA_W-1:0] rd_data_out,
   // memory pins
   output asp_pkg::asp_pins_s         mem_out,
   input  wire logic [asp_pkg::ASP_DATA_W-1:0] shared_data_lines_in
);
   import asp_pkg::*;

   localparam logic [ASP_CNT_W-1:0] RD_CNT  = ASP_CNT_W'(ASP_RD_CYC + 3);
   localparam logic [ASP_CNT_W-1:0] WR_CNT  = ASP_CNT_W'(ASP_WR_CYC);
   localparam logic [ASP_CNT_W-1:0] REL_CNT = ASP_CNT_W'(ASP_REL_CYC);

   typedef struct packed {
      asp_state_e            state;
      logic [ASP_CNT_W-1:0]  cnt;
      asp_pins_s             pins;
      logic                  rd_valid;
      logic [ASP_DATA_W-1:0] rd_data;
   } asp_ctrl_s;

   asp_ctrl_s st_r;
   asp_ctrl_s st_nxt;
   logic [ASP_DATA_W-1:0] data_sync;

   function automatic asp_pins_s idle_pins(input asp_pins_s p);
      asp_pins_s q;
      q = p;
      q.sel_n = 1'b1;
      q.out_n = 1'b1;
      q.wr_n = 1'b1;
      q.data_oe = 1'b0;
      return q;
   endfunction

   asp_sync #(
      .W(ASP_DATA_W)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .nrst_in    (nrst_in),
      .d_in       (shared_data_lines_in),
      .q_out      (data_sync)
   );

   // a request is taken only in idle; holding the bus busy is the back-pressure
   assign req_ready_out = (st_r.state == ASP_IDLE);

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;
      unique case (st_r.state)
         ASP_IDLE: begin
            st_nxt.pins = idle_pins(st_r.pins);
            if (req_in.valid) begin
               st_nxt.pins.addr = req_in.addr;
               st_nxt.pins.sel_n = 1'b0;
               if (req_in.write) begin
                  // strobe and select fall together; data driven from start
                  st_nxt.pins.wr_n = 1'b0;
                  st_nxt.pins.wdata = req_in.wdata;
                  st_nxt.pins.data_oe = 1'b1;
                  st_nxt.cnt = WR_CNT;
                  st_nxt.state = ASP_WRITE;
               end else begin
                  st_nxt.pins.out_n = 1'b0;
                  st_nxt.cnt = RD_CNT;
                  st_nxt.state = ASP_READ;
               end
            end
         end
         ASP_READ: begin
            // wait access time plus synchroniser depth before capture
            // select and output drive fall with the address, so one wait covers all
            // select stays low for the power-up time
            if (st_r.cnt == ASP_CNT_RST) begin
               // byte read back from the addressed location
               st_nxt.rd_data = data_sync;
               st_nxt.rd_valid = 1'b1;
               // select and output drive rise together, release time follows
               // no drive and no new access during release
               st_nxt.pins = idle_pins(st_r.pins);
               st_nxt.cnt = REL_CNT;
               st_nxt.state = ASP_TURN;
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         ASP_WRITE: begin
            // pulse held for the longer of pulse and cycle minimum
            // address stands through the whole pulse
            if (st_r.cnt == 4'h1) begin
               // strobe rises first and ends the write
               st_nxt.pins.wr_n = 1'b1;
               st_nxt.state = ASP_REC;
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         ASP_REC: begin
            // address and data held one cycle past the strobe edge
            // data stable beyond the terminating edge
            st_nxt.pins = idle_pins(st_r.pins);
            st_nxt.cnt = REL_CNT;
            st_nxt.state = ASP_TURN;
         end
         ASP_TURN: begin
            if (st_r.cnt == 4'h1) begin
               st_nxt.state = ASP_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         default: begin
            st_nxt.pins = idle_pins(st_r.pins);
            st_nxt.state = ASP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r.state <= ASP_IDLE;
         st_r.cnt <= ASP_CNT_RST;
         st_r.pins.sel_n <= 1'b1;
         st_r.pins.out_n <= 1'b1;
         st_r.pins.wr_n <= 1'b1;
         st_r.pins.addr <= ASP_ADDR_RST;
         st_r.pins.wdata <= ASP_DATA_RST;
         st_r.pins.data_oe <= 1'b0;
         st_r.rd_valid <= 1'b0;
         st_r.rd_data <= ASP_DATA_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mem_out = st_r.pins;
   assign rd_valid_out = st_r.rd_valid;
   assign rd_data_out = st_r.rd_data;

   a_addr_wr_stable: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (!mem_out.wr_n && !$past(mem_out.wr_n)) |-> $stable(mem_out.addr))
      else $error("address moved during write pulse");
   a_wr_pulse_len: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $fell(mem_out.wr_n) |-> !mem_out.wr_n [*2] ##1 mem_out.wr_n)
      else $error("write pulse length wrong");
   a_wr_end_first: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $rose(mem_out.wr_n) |-> !mem_out.sel_n && mem_out.data_oe && $stable(mem_out.addr))
      else $error("write not ended by strobe with hold");
   a_no_contention: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      mem_out.data_oe |-> mem_out.out_n)
      else $error("controller drives while memory may drive");
   a_data_before_end: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $fell(mem_out.wr_n) |-> mem_out.data_oe [*2] ##1 (mem_out.data_oe && mem_out.wr_n))
      else $error("write data not held around strobe");
   a_read_wait: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $fell(mem_out.out_n) |-> !rd_valid_out [*6] ##1 rd_valid_out)
      else $error("read captured at wrong time");
   a_release_gap: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $rose(mem_out.sel_n) |-> mem_out.sel_n ##1 mem_out.sel_n)
      else $error("access restarted before release time");
   a_idle_deselect: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      mem_out.sel_n |-> (mem_out.out_n && mem_out.wr_n && !mem_out.data_oe))
      else $error("strobes active while deselected");
   a_wdata_steady: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (!mem_out.wr_n && !$past(mem_out.wr_n)) |-> $stable(mem_out.wdata))
      else $error("write data moved during write pulse");
   a_addr_rd_stable: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (!mem_out.out_n && !$past(mem_out.out_n)) |-> $stable(mem_out.addr))
      else $error("address moved during read");
   a_rd_sel_held: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $fell(mem_out.out_n) |-> !mem_out.sel_n [*6] ##1 mem_out.sel_n)
      else $error("select not held through read access");
   a_wr_out_high: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      !mem_out.wr_n |-> mem_out.out_n)
      else $error("output drive low during write");
   a_wr_addr_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $rose(mem_out.wr_n) |-> ##1 (mem_out.sel_n && !mem_out.data_oe && $stable(mem_out.addr)))
      else $error("address or data not held past write end");
   a_out_release: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $rose(mem_out.out_n) |-> !mem_out.data_oe ##1 !mem_out.data_oe)
      else $error("data driven inside release time");
endmodule

/* logic/asp_pkg.sv */
/*
 asp_pkg: constants and carriers for the asynchronous static memory controller.
 assumes a 20 MHz core clock; the select and address access, write pulse, write cycle and release times are rounded up to whole cycles of it.
*/
package asp_pkg;
   localparam int ASP_ADDR_W       = 19;
   localparam int ASP_DATA_W       = 8;
   localparam int ASP_CLK_PERIOD_NS = 50;
   // timing figures in ns
   localparam int ASP_T_CYCLE_NS   = 55;
   localparam int ASP_T_ACC_ADDR_NS = 55;
   localparam int ASP_T_ACC_SEL_NS = 55;
   localparam int ASP_T_ACC_OUT_NS = 25;
   localparam int ASP_T_PWRUP_NS   = 55;
   localparam int ASP_T_RELEASE_NS = 20;
   localparam int ASP_T_WPULSE_NS  = 45;
   localparam int ASP_T_ADDR_WEND_NS = 45;
   localparam int ASP_T_DSETUP_NS  = 25;
   localparam int ASP_T_WREC_NS    = 5;
   // least times round up, at least one cycle
   function automatic int asp_up(input int ns);
      int c;
      c = (ns + ASP_CLK_PERIOD_NS - 1) / ASP_CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int ASP_RD_CYC = asp_up(ASP_T_ACC_SEL_NS) > asp_up(ASP_T_ACC_ADDR_NS) ?
                               asp_up(ASP_T_ACC_SEL_NS) : asp_up(ASP_T_ACC_ADDR_NS);
   localparam int ASP_WR_CYC_A = asp_up(ASP_T_WPULSE_NS);
   localparam int ASP_WR_CYC_B = asp_up(ASP_T_CYCLE_NS);
   localparam int ASP_WR_CYC = ASP_WR_CYC_A > ASP_WR_CYC_B ? ASP_WR_CYC_A : ASP_WR_CYC_B;
   localparam int ASP_REL_CYC = asp_up(ASP_T_RELEASE_NS);
   localparam int ASP_CNT_W   = 4;
   localparam logic [ASP_CNT_W-1:0] ASP_CNT_RST = 4'h0;
   localparam logic [ASP_ADDR_W-1:0] ASP_ADDR_RST = 19'h00000;
   localparam logic [ASP_DATA_W-1:0] ASP_DATA_RST = 8'h00;

   typedef enum logic [4:0] {
      ASP_IDLE  = 5'b00001,
      ASP_READ  = 5'b00010,
      ASP_WRITE = 5'b00100,
      ASP_REC   = 5'b01000,
      ASP_TURN  = 5'b10000
   } asp_state_e;

   typedef struct packed {
      logic                  sel_n;
      logic                  out_n;
      logic                  wr_n;
      logic [ASP_ADDR_W-1:0] addr;
      logic [ASP_DATA_W-1:0] wdata;
      logic                  data_oe;
   } asp_pins_s;

   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [ASP_ADDR_W-1:0] addr;
      logic [ASP_DATA_W-1:0] wdata;
   } asp_req_s;
endpackage

/* logic/asp_sync.sv */
/*
 asp_sync: three-stage synchroniser for the returning data lines.
 assumes the input is asynchronous; a bit changes once stages two and three agree.
*/
module asp_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         nrst_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } asp_sync_s;
   asp_sync_s st_r;
   asp_sync_s st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q_out = st_r.q;
endmodule

/* verification/asp_sram_model.sv */
/*
 asp_sram_model: behavioural 512K x 8 asynchronous static memory for the controller bench.
 assumes the bench resolves the shared data lines and feeds the resolved level back as data_in.
*/
module asp_sram_model
   import asp_pkg::*;
(
   // memory pins
   input  wire asp_pkg::asp_pins_s             pins_in,
   input  wire logic [asp_pkg::ASP_DATA_W-1:0] data_in,
   output logic      [asp_pkg::ASP_DATA_W-1:0] dq_out,
   // count of master timing faults
   output int                                  viol_out
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam realtime    T_OHOLD_NS = 5;
   logic [ASP_DATA_W-1:0] mem [int];
   realtime               ta = 0;
   realtime               ts = 0;
   realtime               to = 0;
   realtime               td = 0;
   realtime               tw = 0;
   logic                  rd;
   logic                  wact;
   initial begin
      dq_out = 8'h00;
      viol_out = 0;
   end
   // read mode needs strobe high, drive and select low
   assign rd   = !pins_in.sel_n && !pins_in.out_n && pins_in.wr_n;
   // write mode while select and strobe are both low
   assign wact = !pins_in.sel_n && !pins_in.wr_n;
   always @(pins_in.addr) ta = $realtime;
   always @(negedge pins_in.sel_n) ts = $realtime;
   always @(negedge pins_in.out_n) to = $realtime;
   always @(data_in) td = $realtime;
   always @(posedge wact) tw = $realtime;
   // byte stored at the earlier rising edge; master timing judged there
   always @(negedge wact) begin
      if (tw > 0) begin
         if ($realtime - tw < ASP_T_WPULSE_NS || $realtime - td < ASP_T_DSETUP_NS || ta > tw
             || $realtime - ta < ASP_T_ADDR_WEND_NS)
            viol_out++;
         mem[pins_in.addr] = data_in;
      end
   end
   // stored byte only once every access time has run out
   // outside read mode the lines float, seen as changing garbage
   // old byte kept for a moment after the address moves
   always #1 begin
      if (rd && $realtime >= ta + ASP_T_ACC_ADDR_NS && $realtime >= ts + ASP_T_ACC_SEL_NS
          && $realtime >= to + ASP_T_ACC_OUT_NS)
         dq_out = mem[pins_in.addr];
      else if (!rd || $realtime >= ta + T_OHOLD_NS)
         dq_out = ~dq_out;
      // contention if the master drives while the memory is reading out
      if (rd && pins_in.data_oe)
         viol_out++;
   end
endmodule

/* verification/testbench.sv */
/*
 testbench: runs a table of writes and reads through the controller into the memory model.
 assumes the model keeps its contents across a controller reset, as a real memory does.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import asp_pkg::*;
   typedef struct packed {
      logic                  wr;
      logic [ASP_ADDR_W-1:0] a;
      logic [ASP_DATA_W-1:0] d;
   } asp_row_s;
   logic                  core_clk;
   logic                  nrst;
   asp_req_s              req;
   logic                  req_ready;
   logic                  rd_valid;
   logic [ASP_DATA_W-1:0] rd_data;
   logic [ASP_DATA_W-1:0] dev_dq;
   logic [ASP_DATA_W-1:0] dq_bus;
   asp_pins_s             pins;
   int                    error_cnt = 0;
   int                    total_checks = 0;
   int                    viol;
   int                    n;
   // boundary addresses, an overwrite, and reads right behind writes
   asp_row_s rows [8] = '{'{1'h1, 19'h00000, 8'hA5}, '{1'h1, 19'h7FFFF, 8'h5A}, '{1'h0, 19'h00000, 8'hA5},
                          '{1'h0, 19'h7FFFF, 8'h5A}, '{1'h1, 19'h00000, 8'h3C}, '{1'h0, 19'h00000, 8'h3C},
                          '{1'h1, 19'h2AAAA, 8'h81}, '{1'h0, 19'h2AAAA, 8'h81}};
   // controller drives the lines only with its enable up; otherwise the memory side shows
   assign dq_bus = pins.data_oe ? pins.wdata : dev_dq;
   asp_ctrl asp_ctrl_inst (.core_clk_in(core_clk), .nrst_in(nrst), .req_in(req), .req_ready_out(req_ready),
                           .rd_valid_out(rd_valid), .rd_data_out(rd_data), .mem_out(pins),
                           .shared_data_lines_in(dq_bus));
   asp_sram_model asp_sram_model_inst (.pins_in(pins), .data_in(dq_bus), .dq_out(dev_dq), .viol_out(viol));
   initial begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one request; poke offers a refused write while the controller is busy
   task automatic access(input asp_row_s r, input bit poke);
      @(posedge core_clk);
      req <= '{1'h1, r.wr, r.a, r.d};
      @(negedge core_clk);
      for (n = 0; !req_ready && n < 20; n++) @(negedge core_clk);
      @(posedge core_clk);
      req <= '0;
      if (poke) begin
         @(posedge core_clk);
         req <= '{1'h1, 1'h1, r.a, ~r.d};
         @(posedge core_clk);
         req <= '0;
      end
      n = 0;
      if (!r.wr) begin
         do begin
            @(negedge core_clk);
            n++;
         end while (!rd_valid && n < 20);
         // valid rises at the sixth edge after the take and is seen on the negedge behind it
         check(n, 7);
         check(rd_data, r.d);
      end else begin
         // step off the take edge so ready is read after the state has moved
         @(negedge core_clk);
      end
      for (n = 0; !req_ready && n < 20; n++) @(negedge core_clk);
      check({pins.sel_n, pins.data_oe}, 2'h2);
   endtask
   initial begin
      repeat (2000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end
   initial begin
      req = '0;
      nrst = 1'h0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'h1;
      foreach (rows[i]) access(rows[i], 1'b0);
      access('{1'h1, 19'h12345, 8'hC3}, 1'b1);
      access('{1'h0, 19'h12345, 8'hC3}, 1'b0);
      @(posedge core_clk);
      nrst <= 1'h0;
      @(negedge core_clk);
      check({pins.sel_n, pins.out_n, pins.wr_n, pins.data_oe, req_ready, rd_valid}, 6'h3A);
      repeat (2) @(posedge core_clk);
      nrst <= 1'h1;
      access('{1'h0, 19'h7FFFF, 8'h5A}, 1'b0);
      check(viol, 0);
      summarize();
   end
endmodule
